//--- logic/iseq_pkg.sv
package iseq_pkg;
   // Next-cycle type codes
   localparam logic [1:0] CT_INT = 2'h0;
   localparam logic [1:0] CT_COP = 2'h1;
   localparam logic [1:0] CT_NSEQ = 2'h2;
   localparam logic [1:0] CT_SEQ = 2'h3;
   // Transfer size codes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   // Address steps
   localparam logic [31:0] STEP_WIDE = 32'h4;
   localparam logic [31:0] STEP_COMPACT = 32'h2;
   localparam logic [31:0] WORD_STEP = 32'h4;
   // Reset values
   localparam logic [31:0] ADDR_RST = 32'h0;
   localparam logic [4:0] CNT_RST = 5'h0;
   localparam logic [7:0] SHAMT_RST = 8'h0;
   // Multiplier early-termination tiers
   localparam int MUL_TIER1_LSB = 8;
   localparam int MUL_TIER2_LSB = 16;
   localparam int MUL_TIER3_LSB = 24;
   localparam logic [2:0] MUL_M1 = 3'h1;
   localparam logic [2:0] MUL_M2 = 3'h2;
   localparam logic [2:0] MUL_M3 = 3'h3;
   localparam logic [2:0] MUL_M4 = 3'h4;

   typedef enum logic [2:0] {
      OP_DATA = 3'h0,
      OP_PSR = 3'h1,
      OP_MUL = 3'h2,
      OP_LDR = 3'h3,
      OP_STR = 3'h4,
      OP_LDM = 3'h5
   } iseq_op_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_FIRST = 4'h1,
      ST_SHIFT = 4'h3,
      ST_MULT = 4'h2,
      ST_DATA = 4'h6,
      ST_LAST = 4'h7,
      ST_REFILL1 = 4'h5,
      ST_REFILL2 = 4'h4
   } iseq_state_t;

   typedef struct packed {
      logic valid;
      iseq_op_t op;
      logic dest_pc;
      logic reg_shift;
      logic test_only;
      logic accumulate;
      logic long_mul;
      logic user_xlate;
      logic [1:0] data_size;
      logic [4:0] word_count;
      logic list_has_pc;
   } iseq_cmd_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] next_cycle_type;
      logic opcode_or_data_flag;
      logic privileged_access_flag;
      logic write;
      logic [1:0] size;
   } iseq_bus_t;
endpackage : iseq_pkg

//--- logic/iseq_sequencer.sv
module iseq_sequencer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Decoded instruction
   input wire iseq_pkg::iseq_cmd_t cmd,
   input wire logic compact_state,
   input wire logic priv_mode,
   // Datapath values
   input wire logic [31:0] fetch_addr,
   input wire logic [31:0] target_addr,
   input wire logic [31:0] data_address,
   input wire logic [31:0] new_base,
   input wire logic [31:0] multiplier_operand,
   input wire logic [31:0] shift_amount_register,
   // Memory answer
   input wire logic abort,
   // Bus request
   output iseq_pkg::iseq_bus_t bus,
   // Register file and core control
   output logic cmd_ready,
   output logic dest_write,
   output logic flags_write,
   output logic base_restore,
   output logic [31:0] restore_value,
   output logic shift_latch_load,
   output logic [7:0] shift_amount,
   output logic exception_lockout,
   output logic op_rejected
);
   import iseq_pkg::*;

   typedef struct packed {
      iseq_state_t st;
      iseq_cmd_t op;
      logic compact;
      logic [31:0] fetch;
      logic [31:0] daddr;
      logic [31:0] tgt;
      logic [4:0] cnt;
      logic aborted;
      logic [31:0] saved_base;
      iseq_bus_t bus;
      logic ready;
      logic dest_write;
      logic flags_write;
      logic base_restore;
      logic shift_load;
      logic [7:0] shift_amt;
      logic lockout;
      logic reject;
   } iseq_regs_t;

   iseq_regs_t s;
   iseq_regs_t next_s;

   function automatic logic [2:0] mul_cycles(input logic [31:0] v);
      logic [2:0] m;
      m = MUL_M4;
      if ((&v[31:MUL_TIER3_LSB]) || !(|v[31:MUL_TIER3_LSB])) begin
         m = MUL_M3;
      end
      if ((&v[31:MUL_TIER2_LSB]) || !(|v[31:MUL_TIER2_LSB])) begin
         m = MUL_M2;
      end
      if ((&v[31:MUL_TIER1_LSB]) || !(|v[31:MUL_TIER1_LSB])) begin
         m = MUL_M1;
      end
      return m;
   endfunction : mul_cycles

   logic [31:0] step;
   logic illegal;
   logic pc_reload;
   logic [4:0] mul_extra;

   always_comb begin
      next_s = s;
      step = next_s.compact ? STEP_COMPACT : STEP_WIDE;
      illegal = compact_state && ((cmd.op == OP_DATA && cmd.reg_shift && cmd.dest_pc)
         || (cmd.op == OP_MUL && cmd.long_mul));
      mul_extra = 5'(mul_cycles(multiplier_operand)) + 5'(s.op.accumulate) + 5'(s.op.long_mul);
      pc_reload = 1'b0;
      next_s.dest_write = 1'b0;
      next_s.flags_write = 1'b0;
      next_s.base_restore = 1'b0;
      next_s.shift_load = 1'b0;
      next_s.reject = 1'b0;
      unique case (s.st)
         ST_IDLE: begin
            if (cmd.valid && illegal) begin
               next_s.reject = 1'b1;
            end else if (cmd.valid) begin
               next_s.st = ST_FIRST;
               next_s.op = cmd;
               next_s.op.dest_pc = cmd.dest_pc && cmd.op != OP_PSR;
               next_s.compact = compact_state;
               next_s.fetch = fetch_addr;
               next_s.aborted = 1'b0;
               next_s.shift_load = cmd.reg_shift && cmd.op == OP_DATA;
               next_s.shift_amt = shift_amount_register[7:0];
            end
         end
         ST_FIRST: begin
            unique case (s.op.op)
               OP_MUL: begin
                  next_s.st = ST_MULT;
                  next_s.cnt = mul_extra - 5'h1;
               end
               OP_LDR, OP_STR: begin
                  next_s.st = ST_DATA;
                  next_s.cnt = CNT_RST;
                  next_s.daddr = data_address;
               end
               OP_LDM: begin
                  next_s.st = ST_DATA;
                  next_s.cnt = s.op.word_count - 5'h1;
                  next_s.daddr = data_address;
                  next_s.saved_base = new_base;
               end
               default: begin
                  if (s.op.reg_shift) begin
                     next_s.st = ST_SHIFT;
                  end else if (s.op.dest_pc) begin
                     next_s.st = ST_REFILL1;
                  end else begin
                     next_s.st = ST_IDLE;
                  end
               end
            endcase
         end
         ST_SHIFT: begin
            next_s.st = s.op.dest_pc ? ST_REFILL1 : ST_IDLE;
         end
         ST_MULT: begin
            if (s.cnt == CNT_RST) begin
               next_s.st = ST_IDLE;
            end else begin
               next_s.cnt = s.cnt - 5'h1;
            end
         end
         ST_DATA: begin
            next_s.aborted = s.aborted || abort;
            next_s.daddr = s.daddr + WORD_STEP;
            if (s.op.op == OP_STR) begin
               next_s.st = ST_IDLE;
            end else if (s.cnt == CNT_RST) begin
               next_s.st = ST_LAST;
            end else begin
               next_s.cnt = s.cnt - 5'h1;
               next_s.dest_write = !next_s.aborted;
            end
         end
         ST_LAST: begin
            pc_reload = (s.op.op == OP_LDR && s.op.dest_pc) || (s.op.op == OP_LDM && s.op.list_has_pc);
            next_s.st = (pc_reload && !s.aborted) ? ST_REFILL1 : ST_IDLE;
         end
         ST_REFILL1: begin
            next_s.st = ST_REFILL2;
         end
         ST_REFILL2: begin
            next_s.st = ST_IDLE;
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase

      // Bus row for the cycle being entered
      next_s.bus.write = 1'b0;
      next_s.bus.opcode_or_data_flag = 1'b1;
      next_s.bus.privileged_access_flag = priv_mode;
      next_s.bus.size = next_s.compact ? SZ_HALF : SZ_WORD;
      next_s.bus.next_cycle_type = CT_INT;
      unique case (next_s.st)
         ST_IDLE: begin
            next_s.bus.addr = s.bus.addr;
         end
         ST_FIRST: begin
            next_s.bus.addr = next_s.fetch;
            next_s.bus.opcode_or_data_flag = 1'b0;
            unique case (next_s.op.op)
               OP_MUL: begin
                  next_s.bus.next_cycle_type = CT_INT;
               end
               OP_LDR, OP_STR, OP_LDM: begin
                  next_s.bus.next_cycle_type = CT_NSEQ;
               end
               default: begin
                  if (next_s.op.reg_shift) begin
                     next_s.bus.next_cycle_type = CT_INT;
                  end else if (next_s.op.dest_pc) begin
                     next_s.bus.next_cycle_type = CT_NSEQ;
                  end else begin
                     next_s.bus.next_cycle_type = CT_SEQ;
                     next_s.dest_write = !next_s.op.test_only;
                     next_s.flags_write = next_s.op.test_only;
                  end
               end
            endcase
            if (!next_s.op.reg_shift && next_s.op.dest_pc && next_s.op.op == OP_DATA) begin
               next_s.dest_write = 1'b1;
            end
         end
         ST_SHIFT: begin
            next_s.bus.addr = next_s.fetch + step;
            next_s.bus.next_cycle_type = next_s.op.dest_pc ? CT_NSEQ : CT_SEQ;
            next_s.dest_write = !next_s.op.test_only;
            next_s.flags_write = next_s.op.test_only;
         end
         ST_MULT: begin
            next_s.bus.addr = (s.st == ST_FIRST && next_s.op.accumulate) ? next_s.fetch : next_s.fetch + step;
            next_s.bus.next_cycle_type = (next_s.cnt == CNT_RST) ? CT_SEQ : CT_INT;
            next_s.dest_write = next_s.cnt == CNT_RST;
         end
         ST_DATA: begin
            next_s.bus.addr = next_s.daddr;
            next_s.bus.write = next_s.op.op == OP_STR;
            next_s.bus.size = (next_s.op.op == OP_LDM) ? SZ_WORD : next_s.op.data_size;
            if (next_s.op.user_xlate && next_s.op.op != OP_LDM) begin
               next_s.bus.privileged_access_flag = 1'b0;
            end
            if (next_s.op.op == OP_STR) begin
               next_s.bus.next_cycle_type = CT_NSEQ;
            end else begin
               next_s.bus.next_cycle_type = (next_s.cnt == CNT_RST) ? CT_INT : CT_SEQ;
            end
         end
         ST_LAST: begin
            next_s.bus.addr = next_s.fetch + step;
            pc_reload = (next_s.op.op == OP_LDR && next_s.op.dest_pc)
               || (next_s.op.op == OP_LDM && next_s.op.list_has_pc);
            next_s.bus.next_cycle_type = (pc_reload && !next_s.aborted) ? CT_NSEQ : CT_SEQ;
            next_s.dest_write = !next_s.aborted;
            next_s.base_restore = next_s.aborted && next_s.op.op == OP_LDM;
         end
         ST_REFILL1: begin
            next_s.tgt = target_addr;
            next_s.bus.addr = target_addr;
            next_s.bus.opcode_or_data_flag = 1'b0;
            next_s.bus.next_cycle_type = CT_SEQ;
         end
         ST_REFILL2: begin
            next_s.bus.addr = next_s.tgt + step;
            next_s.bus.opcode_or_data_flag = 1'b0;
            next_s.bus.next_cycle_type = CT_SEQ;
         end
         default: begin
            next_s.bus.addr = s.bus.addr;
         end
      endcase
      // Held through the whole refill so no exception sees a half-filled pipeline
      next_s.lockout = next_s.st == ST_REFILL1 || next_s.st == ST_REFILL2;
      next_s.ready = next_s.st == ST_IDLE;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s.st <= ST_IDLE;
         s.op <= '0;
         s.compact <= 1'b0;
         s.fetch <= ADDR_RST;
         s.daddr <= ADDR_RST;
         s.tgt <= ADDR_RST;
         s.cnt <= CNT_RST;
         s.aborted <= 1'b0;
         s.saved_base <= ADDR_RST;
         s.bus <= '{addr: ADDR_RST, next_cycle_type: CT_INT, opcode_or_data_flag: 1'b1,
            privileged_access_flag: 1'b0, write: 1'b0, size: SZ_WORD};
         s.ready <= 1'b1;
         s.dest_write <= 1'b0;
         s.flags_write <= 1'b0;
         s.base_restore <= 1'b0;
         s.shift_load <= 1'b0;
         s.shift_amt <= SHAMT_RST;
         s.lockout <= 1'b0;
         s.reject <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign bus = s.bus;
   assign cmd_ready = s.ready;
   assign dest_write = s.dest_write;
   assign flags_write = s.flags_write;
   assign base_restore = s.base_restore;
   assign restore_value = s.saved_base;
   assign shift_latch_load = s.shift_load;
   assign shift_amount = s.shift_amt;
   assign exception_lockout = s.lockout;
   assign op_rejected = s.reject;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence refill_pair;
      s.st == ST_REFILL1 && bus.next_cycle_type == CT_SEQ && !bus.opcode_or_data_flag
      ##1 s.st == ST_REFILL2 && bus.addr == $past(bus.addr) + (s.compact ? STEP_COMPACT : STEP_WIDE);
   endsequence

   sequence shift_pc_tail;
      s.st == ST_SHIFT && bus.next_cycle_type == CT_NSEQ ##1 refill_pair;
   endsequence

   a_reject_long_mul:
      assert property (s.ready && cmd.valid && compact_state && cmd.op == OP_MUL && cmd.long_mul
         |=> op_rejected && cmd_ready)
      else $error("long multiply accepted in compact state");

   a_reject_shift_pc:
      assert property (s.ready && cmd.valid && compact_state && cmd.op == OP_DATA && cmd.reg_shift
         && cmd.dest_pc |=> op_rejected ##1 cmd_ready)
      else $error("shifted pc write accepted in compact state");

   a_first_prefetch:
      assert property ($rose(s.st == ST_FIRST) |-> !bus.opcode_or_data_flag && bus.addr == s.fetch)
      else $error("first cycle does not prefetch");

   a_refill_seq:
      assert property ($rose(s.st == ST_REFILL1) |-> refill_pair ##1 cmd_ready)
      else $error("refill sequence broken");

   a_shift_pc_order:
      assert property (s.st == ST_FIRST && s.op.reg_shift && s.op.dest_pc
         |-> bus.next_cycle_type == CT_INT ##1 shift_pc_tail)
      else $error("shifted pc write order wrong");

   a_lockout_refill:
      assert property (exception_lockout |-> bus.next_cycle_type == CT_SEQ && !cmd_ready)
      else $error("lockout outside refill");

   a_shift_latch:
      assert property (shift_latch_load |-> bus.next_cycle_type == CT_INT
         ##1 !shift_latch_load && s.st == ST_SHIFT && bus.opcode_or_data_flag)
      else $error("shift latch cycle wrong");

   a_store_write:
      assert property (bus.write |-> bus.next_cycle_type == CT_NSEQ && bus.opcode_or_data_flag
         ##1 cmd_ready)
      else $error("store write cycle wrong");

   a_user_xlate:
      assert property (s.st == ST_DATA && s.op.user_xlate && s.op.op != OP_LDM
         |-> !bus.privileged_access_flag)
      else $error("user translation not applied");

   a_ldr_abort:
      assert property (s.st == ST_DATA && s.op.op == OP_LDR && abort |=> s.st == ST_LAST && !dest_write)
      else $error("aborted load wrote destination");

   a_ldm_suppress:
      assert property (s.op.op == OP_LDM && s.aborted && s.st != ST_IDLE |-> !dest_write)
      else $error("register write after abort");

   a_ldm_restore:
      assert property (s.st == ST_LAST && s.op.op == OP_LDM |-> base_restore == s.aborted)
      else $error("base not restored after abort");

   a_mul_end:
      assert property (s.st == ST_MULT && bus.next_cycle_type == CT_SEQ |=> cmd_ready)
      else $error("multiply did not end after sequential type");
endmodule : iseq_sequencer

//--- tb/iseq_mem_model.sv
module iseq_mem_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Core bus
   input wire iseq_pkg::iseq_bus_t bus,
   // Fault injection from the bench
   input wire logic abort_en,
   input wire logic [31:0] abort_addr,
   output logic abort
);
   timeunit 1ns;
   timeprecision 1ps;
   import iseq_pkg::*;

   typedef struct packed {
      logic [1:0] row_type;
   } iseq_mem_st_t;

   iseq_mem_st_t st;
   iseq_mem_st_t next_st;

   // A row's own type was announced one row earlier
   always_comb begin
      next_st.row_type = bus.next_cycle_type;
   end

   always_ff @(posedge sys_clk) begin
      st <= rst ? '{row_type: CT_INT} : next_st;
   end

   // Internal rows make no request, so they can never fault
   assign abort = abort_en && (st.row_type != CT_INT) && bus.opcode_or_data_flag && (bus.addr == abort_addr);
endmodule : iseq_mem_model

//--- tb/iseq_sequencer_tb.sv
module iseq_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import iseq_pkg::*;

   typedef struct {
      logic [31:0] a;
      int t, f, d, w, p, fw, l, b, z;
   } iseq_row_t;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   iseq_cmd_t cmd;
   logic compact_state;
   logic priv_mode;
   logic [31:0] fetch_addr;
   logic [31:0] target_addr;
   logic [31:0] data_address;
   logic [31:0] new_base;
   logic [31:0] multiplier_operand;
   logic [31:0] shift_amount_register;
   logic [31:0] abort_addr;
   logic abort_en;
   logic abort;
   iseq_bus_t bus;
   logic cmd_ready, dest_write, flags_write, base_restore, shift_latch_load, exception_lockout, op_rejected;
   logic [31:0] restore_value;
   logic [7:0] shift_amount;
   int error_cnt = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h55FAC471;
   iseq_row_t q[$];
   logic [31:0] ops [4] = '{32'h00000012, 32'hFFFF8034, 32'h00AB0000, 32'h12345678};

   always #20 sys_clk = ~sys_clk;

   iseq_sequencer u_dut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .compact_state(compact_state),
      .priv_mode(priv_mode), .fetch_addr(fetch_addr), .target_addr(target_addr), .data_address(data_address),
      .new_base(new_base), .multiplier_operand(multiplier_operand), .shift_amount_register(shift_amount_register),
      .abort(abort), .bus(bus), .cmd_ready(cmd_ready), .dest_write(dest_write), .flags_write(flags_write),
      .base_restore(base_restore), .restore_value(restore_value), .shift_latch_load(shift_latch_load),
      .shift_amount(shift_amount), .exception_lockout(exception_lockout), .op_rejected(op_rejected));

   iseq_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .bus(bus), .abort_en(abort_en),
      .abort_addr(abort_addr), .abort(abort));

   task automatic close_out();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic int mcount(logic [31:0] v);
      if (&v[31:8] || ~|v[31:8]) return 1;
      if (&v[31:16] || ~|v[31:16]) return 2;
      if (&v[31:24] || ~|v[31:24]) return 3;
      return 4;
   endfunction : mcount

   function automatic iseq_cmd_t mk(iseq_op_t op, logic dp = 0, logic rs = 0, logic tst = 0, logic acc = 0,
      logic lng = 0, logic ux = 0, logic [4:0] wc = 5'h1, logic lp = 0);
      iseq_cmd_t c;
      c = '0;
      c.valid = 1'b1;
      c.op = op;
      c.dest_pc = dp;
      c.reg_shift = rs;
      c.test_only = tst;
      c.accumulate = acc;
      c.long_mul = lng;
      c.user_xlate = ux;
      c.data_size = SZ_WORD;
      c.word_count = wc;
      c.list_has_pc = lp;
      return c;
   endfunction : mk

   // Minus one leaves d and fw unchecked; for p and z it expects pv and the default size
   task automatic push(input logic [31:0] a, input int t, input int f, input int d = -1, input int w = 0,
      input int p = -1, input int fw = -1, input int l = 0, input int b = 0, input int z = -1);
      q.push_back('{a, t, f, d, w, p, fw, l, b, z});
   endtask : push

   task automatic refill(input logic [31:0] ta, input int i);
      push(ta, CT_SEQ, 0, -1, 0, -1, -1, 1);
      push(ta + 32'(i), CT_SEQ, 0, -1, 0, -1, -1, 1);
   endtask : refill

   task automatic exec(input iseq_cmd_t c, input logic cs, input int ab, input logic [31:0] mo);
      int i, n, k, r;
      logic [31:0] pc, ta, da, nb, sr, x;
      logic pv, rej, dp, ux;
      iseq_row_t e;
      i = cs ? 2 : 4;
      pc = xs() & 32'h7FFFFFFC;
      ta = xs() & 32'h7FFFFFFC;
      da = (xs() & 32'h7FFFFFFC) | 32'h80000000;
      nb = xs();
      sr = xs();
      x = xs();
      pv = x[0];
      if (c.op == OP_LDR || c.op == OP_STR) c.data_size = (x[2:1] == 2'h3) ? SZ_BYTE : x[2:1];
      ux = c.user_xlate;
      dp = (c.op == OP_DATA) && c.dest_pc;
      rej = cs && ((dp && c.reg_shift) || (c.op == OP_MUL && c.long_mul));
      q.delete();
      case (c.op)
         OP_DATA, OP_PSR: begin
            if (c.reg_shift) begin
               push(pc + 32'(2 * i), CT_INT, 0, 0, 0, -1, 0);
               push(pc + 32'(3 * i), dp ? CT_NSEQ : CT_SEQ, 1, !c.test_only, 0, -1, c.test_only);
            end else begin
               push(pc + 32'(2 * i), dp ? CT_NSEQ : CT_SEQ, 0, dp ? 1 : !c.test_only, 0, -1, dp ? 0 : c.test_only);
            end
            if (dp) refill(ta, i);
         end
         OP_MUL: begin
            k = mcount(mo) + c.accumulate + c.long_mul;
            push(pc + 32'(2 * i), CT_INT, 0, 0);
            for (r = 1; r <= k; r++) push((r == 1 && c.accumulate) ? pc + 32'(2 * i) : pc + 32'(3 * i),
               (r == k) ? CT_SEQ : CT_INT, 1, r == k);
         end
         OP_LDR: begin
            push(pc + 32'(2 * i), CT_NSEQ, 0);
            push(da, CT_INT, 1, 0, 0, ux ? 0 : pv, -1, 0, 0, c.data_size);
            push(pc + 32'(3 * i), (c.dest_pc && ab == 0) ? CT_NSEQ : CT_SEQ, 1, ab > 0 ? 0 : 1);
            if (c.dest_pc && ab == 0) refill(ta, i);
         end
         OP_STR: begin
            push(pc + 32'(2 * i), CT_NSEQ, 0);
            push(da, CT_NSEQ, 1, -1, 1, ux ? 0 : pv, -1, 0, 0, c.data_size);
         end
         default: begin
            n = c.word_count;
            push(pc + 32'(2 * i), CT_NSEQ, 0, 0);
            for (k = 0; k < n; k++) begin
               r = k + 2;
               push(da + 32'(4 * k), (k == n - 1) ? CT_INT : CT_SEQ, 1,
                  (r < 3) ? 0 : (ab > 0 && r > ab) ? 0 : 1, 0, -1, -1, 0, 0, SZ_WORD);
            end
            push(pc + 32'(3 * i), (c.list_has_pc && ab == 0) ? CT_NSEQ : CT_SEQ, 1,
               ab > 0 ? 0 : 1, 0, -1, -1, 0, ab > 0);
            if (c.list_has_pc && ab == 0) refill(ta, i);
         end
      endcase
      for (k = 0; k < 20 && cmd_ready !== 1'b1; k++) @(negedge sys_clk);
      if (cmd_ready !== 1'b1) begin
         error_cnt++;
         close_out();
      end
      @(posedge sys_clk);
      cmd <= c;
      compact_state <= cs;
      priv_mode <= pv;
      fetch_addr <= pc + 32'(2 * i);
      target_addr <= ta;
      data_address <= da;
      new_base <= nb;
      multiplier_operand <= mo;
      shift_amount_register <= sr;
      abort_en <= (ab > 0);
      abort_addr <= (c.op == OP_LDM) ? da + 32'(4 * (ab - 2)) : da;
      @(posedge sys_clk);
      cmd.valid <= 1'b0;
      if (rej) begin
         @(negedge sys_clk);
         if (c.op == OP_MUL) check(32'(op_rejected), 32'h1);
         else check(32'(op_rejected), 32'h1);
         check(32'(cmd_ready), 32'h1);
         return;
      end
      for (r = 0; r < q.size(); r++) begin
         @(negedge sys_clk);
         e = q[r];
         if (r == 0) check(32'(cmd_ready), 32'h0);
         if (r == 0) check(32'(op_rejected), 32'h0);
         if (r == 0) check({23'h0, shift_latch_load, shift_amount}, {23'h0, c.reg_shift, sr[7:0]});
         check(32'(bus.size), (e.z >= 0) ? 32'(e.z) : (cs ? 32'(SZ_HALF) : 32'(SZ_WORD)));
         check(bus.addr, e.a);
         check(32'(bus.next_cycle_type), e.t);
         check(32'(bus.opcode_or_data_flag), e.f);
         check(32'(bus.write), e.w);
         check(32'(exception_lockout), e.l);
         check(32'(base_restore), e.b);
         if (e.b == 1) check(restore_value, nb);
         if (e.d >= 0) check(32'(dest_write), e.d);
         check(32'(bus.privileged_access_flag), (e.p >= 0) ? 32'(e.p) : 32'(pv));
         if (e.fw >= 0) check(32'(flags_write), e.fw);
      end
      @(negedge sys_clk);
      check(32'(cmd_ready), 32'h1);
   endtask : exec

   initial begin
      cmd <= '0;
      compact_state <= 1'b0;
      priv_mode <= 1'b0;
      fetch_addr <= xs();
      target_addr <= xs();
      data_address <= xs();
      new_base <= xs();
      multiplier_operand <= xs();
      shift_amount_register <= xs();
      abort_addr <= xs();
      abort_en <= 1'b0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      check({bus.addr[29:0], bus.next_cycle_type}, 32'h0);
      check({bus.opcode_or_data_flag, bus.write, bus.size, cmd_ready}, {1'b1, 1'b0, SZ_WORD, 1'b1});
      for (int cs = 0; cs < 2; cs++) begin
         exec(mk(.op(OP_DATA)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_DATA), .tst(1)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_DATA), .dp(1)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_DATA), .rs(1)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_DATA), .rs(1), .dp(1)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_LDR)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_LDR), .ux(1)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_STR), .ux(1)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_STR)), cs[0], 0, 32'h0);
         exec(mk(.op(OP_LDM), .wc(5'h4)), cs[0], 0, 32'h0);
      end
      exec(mk(.op(OP_PSR), .dp(1)), 1'b0, 0, 32'h0);
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 4; j++) begin
            exec(mk(.op(OP_MUL), .acc(k[0]), .lng(k[1])), 1'b0, 0, ops[j]);
         end
      end
      exec(mk(.op(OP_MUL), .lng(1)), 1'b1, 0, ops[3]);
      exec(mk(.op(OP_LDR), .dp(1)), 1'b0, 0, 32'h0);
      exec(mk(.op(OP_LDR)), 1'b0, 2, 32'h0);
      exec(mk(.op(OP_LDM), .wc(5'h1)), 1'b0, 0, 32'h0);
      exec(mk(.op(OP_LDM), .wc(5'h1), .lp(1)), 1'b0, 0, 32'h0);
      exec(mk(.op(OP_LDM), .wc(5'h3), .lp(1)), 1'b0, 0, 32'h0);
      exec(mk(.op(OP_LDM), .wc(5'h10), .lp(1)), 1'b0, 0, 32'h0);
      exec(mk(.op(OP_LDM), .wc(5'h4)), 1'b0, 4, 32'h0);
      exec(mk(.op(OP_LDM), .wc(5'h3), .lp(1)), 1'b0, 3, 32'h0);
      close_out();
   end
endmodule : iseq_sequencer_tb
